// [logic/wdt_top.sv]
// Watchdog timer with two safety levels and an AHB-Lite register slave.
// Assumes one 125 MHz clock; restart and chip reset requests come from logic on that clock.
// How it works
// - Counter advances on a 1 MHz tick divided down from the system clock.
// - A restart pulse returns the counter to zero.
// - Counter is held at zero while disabled and during any chip reset.
// - Counter reaching the selected period without restart resets the chip.
// - Fuse high gives level 2 initially enabled; low gives level 1 disabled.
// - At level 2 the watchdog can never be disabled.
// - Control bits 7 to 5 always read zero.
// - Change-enable clears itself four clock cycles after being set.
// - Writing zero to enable clears it only while change-enable is set.
// - Prescale writes take effect only while change-enable is set.
// - Writing one to enable turns the watchdog on; permitted zero turns it off.
// - Prescale code n selects 16K times two to the n oscillator cycles.
// - At level 1 enable is set by a plain write of one.
// - At level 2 the enable bit always reads one.
// - Expiry gives a reset pulse of exactly one system clock cycle.
// - Expiry sets the sticky watchdog reset flag.
module wdt_top #(
    parameter int unsigned TIMEOUT_BASE = wdt_pkg::BASE_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        wdt_restart,
    input  wire logic        chip_reset_req,
    input  wire logic        safety_level_fuse,
    output logic             wdt_reset_pulse,
    output logic             irq
);

    // ========================================================================
    // Fuse synchroniser.
    logic                    fuse_meta;
    logic                    fuse_sync;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fuse_meta <= 1'b0;
            fuse_sync <= 1'b0;
        end else begin
            fuse_meta <= safety_level_fuse;
            fuse_sync <= fuse_meta;
        end
    end

    wire level2 = fuse_sync;

    // ========================================================================
    // Bus address phase and data phase.
    logic                    wr_pend;
    logic                    rd_pend;
    logic [7:0]              addr_q;

    wire addr_ok = hsel & hready & htrans[1];
    wire wr_acc  = addr_ok & hwrite;
    wire rd_acc  = addr_ok & ~hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q  <= 8'h00;
        end else begin
            wr_pend <= wr_acc;
            rd_pend <= rd_acc;
            if (addr_ok) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    wire       w_ctrl = wr_pend & (addr_q == wdt_pkg::OFF_CTRL);
    wire       w_clr  = wr_pend & (addr_q == wdt_pkg::OFF_CLR);
    wire       w_en   = wr_pend & (addr_q == wdt_pkg::OFF_EN);
    wire [7:0] wd     = hwdata[7:0];

    // ========================================================================
    // Control register.
    logic                    ce;
    logic [1:0]              ce_cnt;
    logic                    wdt_on;
    logic [2:0]              ps;

    wire on_eff  = wdt_on | level2;
    wire ce_set  = w_ctrl & wd[wdt_pkg::CE_BIT] & wd[wdt_pkg::ON_BIT] & ~ce;
    wire ce_stop = w_ctrl & ce & ~wd[wdt_pkg::CE_BIT];
    wire ps_chg  = wd[wdt_pkg::PS_MSB:0] != ps;
    wire off_try = ~wd[wdt_pkg::ON_BIT] & on_eff;
    wire refused = w_ctrl & ~ce & ~wd[wdt_pkg::CE_BIT] & (off_try | ps_chg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ce     <= 1'b0;
            ce_cnt <= 2'h0;
        end else if (chip_reset_req | ce_stop) begin
            ce     <= 1'b0;
        end else if (ce_set) begin
            ce     <= 1'b1;
            ce_cnt <= wdt_pkg::CE_HOLD;
        end else if (ce) begin
            if (ce_cnt == 2'h0) begin
                ce <= 1'b0;
            end
            ce_cnt <= ce_cnt - 2'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_on <= 1'b0;
            ps     <= wdt_pkg::PS_RST;
        end else if (chip_reset_req) begin
            wdt_on <= 1'b0;
            ps     <= wdt_pkg::PS_RST;
        end else if (w_ctrl) begin
            if (wd[wdt_pkg::ON_BIT]) begin
                wdt_on <= 1'b1;
            end else if (ce) begin
                wdt_on <= 1'b0;
            end
            if (ce) begin
                ps <= wd[wdt_pkg::PS_MSB:0];
            end
        end
    end

    // ========================================================================
    // Oscillator tick and time-out counter.
    logic [wdt_pkg::DIV_W-1:0] div;
    logic [wdt_pkg::CNT_W-1:0] cnt;

    localparam logic [wdt_pkg::DIV_W-1:0] DIV_LAST = wdt_pkg::DIV_W'(wdt_pkg::OSC_DIV - 1);
    localparam logic [wdt_pkg::CNT_W-1:0] BASE     = wdt_pkg::CNT_W'(TIMEOUT_BASE);

    wire                      tick   = div == DIV_LAST;
    wire [wdt_pkg::CNT_W-1:0] limit  = BASE << ps;
    wire                      expire = on_eff & tick & (cnt == limit - 1'b1);
    wire                      clear  = chip_reset_req | ~on_eff | wdt_restart | expire;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div <= '0;
        end else if (tick) begin
            div <= '0;
        end else begin
            div <= div + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
        end else if (clear) begin
            cnt <= '0;
        end else if (tick) begin
            cnt <= cnt + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdt_reset_pulse <= 1'b0;
        end else begin
            wdt_reset_pulse <= expire;
        end
    end

    // ========================================================================
    // Status, interrupt enable and interrupt line.
    logic [wdt_pkg::ST_W-1:0] st;
    logic [wdt_pkg::ST_W-1:0] en;

    wire [wdt_pkg::ST_W-1:0] ev       = {refused, expire};
    wire [wdt_pkg::ST_W-1:0] clr_mask = w_clr ? wd[wdt_pkg::ST_W-1:0] : '0;
    wire [wdt_pkg::ST_W-1:0] next_st  = (st & ~clr_mask) | ev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st  <= wdt_pkg::ST_RST;
            en  <= wdt_pkg::ST_RST;
            irq <= 1'b0;
        end else begin
            st  <= next_st;
            irq <= |(next_st & en);
            if (w_en) begin
                en <= wd[wdt_pkg::ST_W-1:0];
            end
        end
    end

    // ========================================================================
    // Read data and bus response.
    wire [7:0]  ctrl_val = {3'h0, ce, on_eff, ps};
    wire [31:0] rd_mux   = (addr_q == wdt_pkg::OFF_CTRL) ? {24'h0, ctrl_val} :
                           (addr_q == wdt_pkg::OFF_STAT) ? {30'h0, st} :
                           (addr_q == wdt_pkg::OFF_EN)   ? {30'h0, en} : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= ~rd_acc;
            hresp     <= 1'b0;
            if (rd_pend) begin
                hrdata <= rd_mux;
            end
        end
    end

    // ========================================================================
    // Assertions.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic rd_ctrl_done;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ctrl_done <= 1'b0;
        end else begin
            rd_ctrl_done <= rd_pend & (addr_q == wdt_pkg::OFF_CTRL);
        end
    end

    sequence ce_opened;
        $rose(ce) ##0 (!ce_stop && !chip_reset_req) [*3];
    endsequence

    sequence pulse_once;
        wdt_reset_pulse ##1 !wdt_reset_pulse;
    endsequence

    reserved_zero_a: assert property (rd_ctrl_done |-> hrdata[31:5] == 27'h0)
        else $error("Reserved control bits read non-zero.");

    ce_window_a: assert property (ce_opened |-> ##1 ce ##1 !ce)
        else $error("Change-enable not cleared after four cycles.");

    disable_guard_a: assert property (
        (w_ctrl && !ce && wdt_on && !wd[wdt_pkg::ON_BIT] && !chip_reset_req) |=> wdt_on)
        else $error("Enable cleared without change-enable.");

    prescale_lock_a: assert property (
        (w_ctrl && !ce && !chip_reset_req) |=> ps == $past(ps))
        else $error("Prescale changed without change-enable.");

    level2_read_a: assert property ((rd_ctrl_done && level2) |-> hrdata[3])
        else $error("Enable reads zero at safety level 2.");

    restart_clear_a: assert property (wdt_restart |=> cnt == '0)
        else $error("Restart did not clear the counter.");

    disabled_clear_a: assert property (!on_eff |=> cnt == '0)
        else $error("Counter running while disabled.");

    reset_pulse_a: assert property (expire |=> pulse_once)
        else $error("Watchdog reset pulse not one cycle long.");

    flag_set_a: assert property (wdt_reset_pulse |-> st[wdt_pkg::ST_BITE])
        else $error("Watchdog reset flag not set on expiry.");

endmodule

// [common/wdt_pkg.sv]
// Constants shared by the watchdog block: register map, field layout, reset values, timing.
// Assumes a 125 MHz system clock and a 32-bit AHB-Lite register bus.
package wdt_pkg;

    // ========================================================================
    // Register map
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_STAT  = 8'h04;
    localparam logic [7:0] OFF_CLR   = 8'h08;
    localparam logic [7:0] OFF_EN    = 8'h0C;

    // ========================================================================
    // Control register fields
    localparam int         CE_BIT    = 4;
    localparam int         ON_BIT    = 3;
    localparam int         PS_MSB    = 2;
    localparam logic [2:0] PS_RST    = 3'h0;
    localparam logic [1:0] CE_HOLD   = 2'h3;

    // ========================================================================
    // Status, clear and enable fields
    localparam int         ST_W      = 2;
    localparam int         ST_BITE   = 0;
    localparam int         ST_REFUSE = 1;
    localparam logic [1:0] ST_RST    = 2'h0;

    // ========================================================================
    // Timing
    localparam int unsigned HCLK_HZ  = 125_000_000;
    localparam int unsigned OSC_HZ   = 1_000_000;
    localparam int unsigned OSC_DIV  = HCLK_HZ / OSC_HZ;
    localparam int          DIV_W    = 7;
    localparam int unsigned BASE_CYC = 16384;
    localparam int          CNT_W    = 22;

endpackage

// [testbench/tb_top.sv]
// Self-checking testbench for the watchdog block and its AHB-Lite register slave.
// Assumes the design package is compiled first and the block is the only bus slave.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================================
    // Signals
    localparam int unsigned BASE = 4;
    localparam int unsigned DIV  = wdt_pkg::OSC_DIV;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        wdt_restart, chip_reset_req, safety_level_fuse, wdt_reset_pulse, irq;
    logic [31:0] exp_q[$];
    logic        rd_pend, kick, in_win;
    integer      seed;
    int          fails, check_count, cyc, npulse, snap, n;

    wdt_top #(.TIMEOUT_BASE(BASE)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .wdt_restart(wdt_restart), .chip_reset_req(chip_reset_req),
        .safety_level_fuse(safety_level_fuse), .wdt_reset_pulse(wdt_reset_pulse), .irq(irq)
    );

    // ========================================================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic end_of_test();
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ========================================================================
    // Clock, restart source and monitor
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    always @(posedge hclk) wdt_restart <= kick && (($random(seed) & 32'hF) == 0);

    always @(posedge hclk) begin
        cyc++;
        if (cyc > 20000) begin
            fails++;
            end_of_test();
        end else begin
            if (wdt_reset_pulse === 1'b1) npulse++;
            if (rd_pend && hreadyout === 1'b1) begin
                chk(hrdata, exp_q.pop_front());
                rd_pend = 1'b0;
            end
            if (hsel && htrans[1] && !hwrite && hreadyout) rd_pend = 1'b1;
        end
    end

    // ========================================================================
    // Main sequence
    initial begin
        seed = 32'h35B85EDB;
        {hresetn, hsel, hwrite, chip_reset_req, safety_level_fuse, rd_pend} = 6'h0;
        {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
        kick = 1'b1;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(wdt_pkg::OFF_CTRL, 32'h00);
        rd(wdt_pkg::OFF_STAT, 32'h00);
        rd(8'h10, 32'h00);
        wr(wdt_pkg::OFF_CTRL, 32'hEF);
        rd(wdt_pkg::OFF_CTRL, 32'h08);
        rd(wdt_pkg::OFF_STAT, 32'h02);
        chk(irq, 1'b0);
        wr(wdt_pkg::OFF_EN, 32'h03);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b1);
        rd(wdt_pkg::OFF_EN, 32'h03);
        wr(wdt_pkg::OFF_CLR, 32'h02);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
        rd(wdt_pkg::OFF_STAT, 32'h00);
        wr(wdt_pkg::OFF_CTRL, 32'h18);
        wr(wdt_pkg::OFF_CTRL, 32'h05);
        rd(wdt_pkg::OFF_CTRL, 32'h05);
        wr(wdt_pkg::OFF_CTRL, 32'h1D);
        rd(wdt_pkg::OFF_CTRL, 32'h1D);
        rd(wdt_pkg::OFF_CTRL, 32'h0D);
        wr(wdt_pkg::OFF_CTRL, 32'h05);
        rd(wdt_pkg::OFF_CTRL, 32'h0D);
        rd(wdt_pkg::OFF_STAT, 32'h02);
        for (int ps = 0; ps < 3; ps++) begin
            wr(wdt_pkg::OFF_CTRL, 32'h18);
            wr(wdt_pkg::OFF_CTRL, 32'h08 | ps);
            wr(wdt_pkg::OFF_CLR, 32'h03);
            snap = npulse;
            repeat (600) @(posedge hclk);
            chk(npulse, snap);
            kick = 1'b0;
            n = 0;
            while (wdt_reset_pulse !== 1'b1 && n < 20000) begin
                @(posedge hclk);
                n = (wdt_restart === 1'b1) ? 0 : n + 1;
            end
            in_win = n >= ((BASE << ps) - 1) * DIV && n <= ((BASE << ps) + 1) * DIV;
            chk(in_win, 1'b1);
            @(posedge hclk);
            chk(wdt_reset_pulse, 1'b0);
            kick = 1'b1;
            rd(wdt_pkg::OFF_STAT, 32'h01);
        end
        chip_reset_req <= 1'b1;
        @(posedge hclk);
        chip_reset_req <= 1'b0;
        rd(wdt_pkg::OFF_CTRL, 32'h00);
        safety_level_fuse <= 1'b1;
        repeat (3) @(posedge hclk);
        rd(wdt_pkg::OFF_CTRL, 32'h08);
        wr(wdt_pkg::OFF_CTRL, 32'h18);
        wr(wdt_pkg::OFF_CTRL, 32'h00);
        rd(wdt_pkg::OFF_CTRL, 32'h08);
        chk(hresp, 1'b0);
        repeat (2) @(posedge hclk);
        chk(exp_q.size(), 0);
        end_of_test();
    end
endmodule
